// File: msap_addr_bank.sv
`timescale 1ns/1ps
`include "msap_map.svh"

module msap_addr_bank
  import msap_pkg::*;
#(
  parameter int unsigned CLK_HZ = 100_000_000
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // decoded request
  input wire logic REQ_VALID,
  input wire msap_req_t REQ,
  // reply
  output logic RSP_VALID,
  output msap_rsp_t RSP,
  // node state
  output logic [15:0] NODE_ADDR,
  output logic ARMED,
  // serial timing
  input wire logic [2:0] BAUD_SEL,
  output logic [15:0] BIT_RATE,
  output logic BIT_TICK,
  output msap_frame_t FRAME
);

  msap_bank_st_t q, d;
  logic hit;
  logic wr_one;
  logic key_ok;
  logic node_ok;

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  assign hit = REQ_VALID && REQ.slave == q.node_addr[7:0];
  assign wr_one = REQ.func == `MSAP_FC_WRITE_ONE;
  assign key_ok = REQ.data == `MSAP_KEY_VALUE;
  assign node_ok = REQ.data >= `MSAP_NODE_MIN &&
                   REQ.data <= `MSAP_NODE_MAX;

  function automatic msap_rsp_t exc_rsp(input msap_rsp_t r,
                                        input logic [7:0] code);
    msap_rsp_t e;
    e = r;
    e.exc = 1'b1;
    e.func = r.func | `MSAP_EXC_FLAG;
    e.data = {8'h00, code};
    return e;
  endfunction

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    if (hit) begin
      d.rsp_valid = 1'b1;
      d.armed = 1'b0; // key must be the previous request addressed to this node
      d.rsp = '{exc: 1'b0, slave: q.node_addr[7:0], func: REQ.func,
                reg_addr: REQ.reg_addr, data: REQ.data};
      if (wr_one) begin
        if (REQ.reg_addr == `MSAP_REG_KEY) begin
          if (key_ok) begin
            d.armed = 1'b1;
          end else begin
            d.rsp = exc_rsp(d.rsp, `MSAP_EXC_VALUE);
          end
        end else if (REQ.reg_addr == `MSAP_REG_NODE) begin
          if (q.armed && node_ok) begin
            d.node_addr = REQ.data;
          end else begin
            d.rsp = exc_rsp(d.rsp, `MSAP_EXC_VALUE);
          end
        end else begin
          d.rsp = exc_rsp(d.rsp, `MSAP_EXC_ADDR);
        end
      end else if (REQ.func == `MSAP_FC_READ_HOLD) begin
        if (REQ.reg_addr != `MSAP_REG_NODE) begin
          d.rsp = exc_rsp(d.rsp, `MSAP_EXC_ADDR);
        end else if (REQ.data != `MSAP_READ_QTY) begin
          d.rsp = exc_rsp(d.rsp, `MSAP_EXC_VALUE);
        end else begin
          d.rsp.data = q.node_addr;
        end
      end else begin
        d.rsp = exc_rsp(d.rsp, `MSAP_EXC_FUNC);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      q <= '{node_addr: `MSAP_NODE_RST, armed: 1'b0, rsp_valid: 1'b0,
             rsp: '0};
    end else if (CE) begin
      q <= d;
    end
  end

  assign RSP_VALID = q.rsp_valid;
  assign RSP = q.rsp;
  assign NODE_ADDR = q.node_addr;
  assign ARMED = q.armed;

  // ------------------------------------------------------------
  // serial format and bit timing
  // ------------------------------------------------------------
  assign FRAME = '{data_bits: `MSAP_DATA_BITS, parity_en: `MSAP_PARITY_EN,
                   stop_bits: `MSAP_STOP_BITS};

  msap_baud_gen #(
    .CLK_HZ(CLK_HZ)
  ) u_baud (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .sel(BAUD_SEL),
    .rate(BIT_RATE),
    .tick(BIT_TICK)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  logic key_wr;
  logic node_wr;
  assign key_wr = CE && hit && wr_one && REQ.reg_addr == `MSAP_REG_KEY;
  assign node_wr = CE && hit && wr_one && REQ.reg_addr == `MSAP_REG_NODE;

  property p_reset_addr;
    $rose(RSTN) |-> NODE_ADDR == `MSAP_NODE_RST && !ARMED;
  endproperty
  a_reset_addr: assert property (p_reset_addr)
    else $error("node address not default after reset");

  property p_key_arms;
    key_wr && key_ok |=> ARMED && RSP_VALID && !RSP.exc;
  endproperty
  a_key_arms: assert property (p_key_arms)
    else $error("key write did not arm");

  property p_locked_keeps;
    node_wr && !ARMED |=> $stable(NODE_ADDR) && !ARMED;
  endproperty
  a_locked_keeps: assert property (p_locked_keeps)
    else $error("address changed while locked");

  property p_armed_loads;
    node_wr && ARMED && node_ok |=> NODE_ADDR == $past(REQ.data);
  endproperty
  a_armed_loads: assert property (p_armed_loads)
    else $error("armed address write not stored");

  property p_addr_range;
    NODE_ADDR >= `MSAP_NODE_MIN && NODE_ADDR <= `MSAP_NODE_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("node address out of range");

  property p_write_echo;
    node_wr && ARMED && node_ok |=>
      RSP_VALID && !RSP.exc && RSP.func == `MSAP_FC_WRITE_ONE ##1
      (!RSP_VALID || $past(hit || !CE));
  endproperty
  a_write_echo: assert property (p_write_echo)
    else $error("write request not echoed");

  property p_bad_write;
    node_wr && (!ARMED || !node_ok) |=>
      RSP_VALID && RSP.exc && RSP.data[7:0] == `MSAP_EXC_VALUE &&
      $stable(NODE_ADDR);
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("bad address write not refused");

  property p_foreign_silent;
    CE && REQ_VALID && REQ.slave != NODE_ADDR[7:0] |=> !RSP_VALID;
  endproperty
  a_foreign_silent: assert property (p_foreign_silent)
    else $error("answered another node's request");

  property p_other_disarms;
    CE && hit && !(key_wr && key_ok) |=> !ARMED;
  endproperty
  a_other_disarms: assert property (p_other_disarms)
    else $error("armed state kept past another request");

  property p_reply_slave;
    CE && hit |=> RSP_VALID && RSP.slave == $past(NODE_ADDR[7:0]);
  endproperty
  a_reply_slave: assert property (p_reply_slave)
    else $error("reply not from the addressed node");

  property p_bad_func;
    CE && hit && !wr_one && REQ.func != `MSAP_FC_READ_HOLD |=>
      RSP_VALID && RSP.exc && RSP.data[7:0] == `MSAP_EXC_FUNC;
  endproperty
  a_bad_func: assert property (p_bad_func)
    else $error("unsupported function not refused");

  property p_unlock_then_change;
    key_wr && key_ok ##1 node_wr && node_ok ##1 !ARMED && !RSP.exc;
  endproperty
  c_unlock_then_change: cover property (p_unlock_then_change);
  c_refused: cover property (node_wr && !ARMED ##1 RSP.exc);
  c_read_node: cover property (CE && hit && REQ.func == `MSAP_FC_READ_HOLD
                               ##1 RSP_VALID && !RSP.exc);

endmodule

// File: msap_map.svh
`ifndef MSAP_MAP_SVH
`define MSAP_MAP_SVH

// ------------------------------------------------------------
// holding register offsets and values
// ------------------------------------------------------------
`define MSAP_REG_KEY 16'h0004
`define MSAP_REG_NODE 16'h0005
`define MSAP_KEY_VALUE 16'h55AA
`define MSAP_NODE_RST 16'h0002
`define MSAP_NODE_MIN 16'h0001
`define MSAP_NODE_MAX 16'h00F7
`define MSAP_READ_QTY 16'h0001

// ------------------------------------------------------------
// function and exception codes
// ------------------------------------------------------------
`define MSAP_FC_WRITE_ONE 8'h06
`define MSAP_FC_READ_HOLD 8'h03
`define MSAP_EXC_FLAG 8'h80
`define MSAP_EXC_FUNC 8'h01
`define MSAP_EXC_ADDR 8'h02
`define MSAP_EXC_VALUE 8'h03

// ------------------------------------------------------------
// serial format and bit rates
// ------------------------------------------------------------
`define MSAP_DATA_BITS 4'h8
`define MSAP_PARITY_EN 1'h0
`define MSAP_STOP_BITS 2'h1
`define MSAP_BPS_1200 16'h04B0
`define MSAP_BPS_2400 16'h0960
`define MSAP_BPS_4800 16'h12C0
`define MSAP_BPS_9600 16'h2580
`define MSAP_BPS_19200 16'h4B00
`define MSAP_BPS_38400 16'h9600
`define MSAP_SEL_9600 3'h0
`define MSAP_SEL_19200 3'h1
`define MSAP_SEL_38400 3'h2
`define MSAP_SEL_4800 3'h3
`define MSAP_SEL_2400 3'h4
`define MSAP_SEL_1200 3'h5
`define MSAP_DIV_ONE 24'h000001
`define MSAP_DIV_ZERO 24'h000000

`endif

// File: msap_pkg.sv
`include "msap_map.svh"

package msap_pkg;

  // decoded request from the frame layer
  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] reg_addr;
    logic [15:0] data;
  } msap_req_t;

  // reply handed back to the frame layer
  typedef struct packed {
    logic exc;
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] reg_addr;
    logic [15:0] data;
  } msap_rsp_t;

  typedef struct packed {
    logic [3:0] data_bits;
    logic parity_en;
    logic [1:0] stop_bits;
  } msap_frame_t;

  typedef struct packed {
    logic [15:0] node_addr;
    logic armed;
    logic rsp_valid;
    msap_rsp_t rsp;
  } msap_bank_st_t;

  typedef struct packed {
    logic [15:0] rate;
    logic [23:0] div;
    logic [23:0] cnt;
    logic tick;
  } msap_baud_st_t;

endpackage

// File: msap_baud_gen.sv
`timescale 1ns/1ps
`include "msap_map.svh"

module msap_baud_gen
  import msap_pkg::*;
#(
  parameter int unsigned CLK_HZ = 100_000_000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // rate select
  input wire logic [2:0] sel,
  // bit timing
  output logic [15:0] rate,
  output logic tick
);

  generate
    if (CLK_HZ / 38400 < 2) begin : g_chk_fast
      $error("msap_baud_gen: clock too slow for 38400 bit/s");
    end
    if (CLK_HZ / 1200 >= 2 ** 24) begin : g_chk_slow
      $error("msap_baud_gen: divider too narrow for clock");
    end
  endgenerate

  msap_baud_st_t q, d;

  function automatic logic [23:0] div_of(input logic [15:0] bps);
    div_of = 24'(CLK_HZ / {16'h0000, bps});
  endfunction

  // ------------------------------------------------------------
  // rate selection and bit counter
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.tick = 1'b0;
    unique case (sel)
      `MSAP_SEL_9600: d.rate = `MSAP_BPS_9600;
      `MSAP_SEL_19200: d.rate = `MSAP_BPS_19200;
      `MSAP_SEL_4800: d.rate = `MSAP_BPS_4800;
      `MSAP_SEL_2400: d.rate = `MSAP_BPS_2400;
      `MSAP_SEL_1200: d.rate = `MSAP_BPS_1200;
      default: d.rate = `MSAP_BPS_38400; // faster codes clamp
    endcase
    d.div = div_of(d.rate);
    if (q.div != d.div || q.cnt == `MSAP_DIV_ZERO) begin
      d.cnt = d.div - `MSAP_DIV_ONE;
      d.tick = (q.div == d.div);
    end else begin
      d.cnt = q.cnt - `MSAP_DIV_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '{rate: `MSAP_BPS_9600, div: `MSAP_DIV_ZERO,
             cnt: `MSAP_DIV_ZERO, tick: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign rate = q.rate;
  assign tick = q.tick;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_rate_cap;
    @(posedge clk) disable iff (!rstn)
    rate <= `MSAP_BPS_38400 && rate >= `MSAP_BPS_1200;
  endproperty
  a_rate_cap: assert property (p_rate_cap)
    else $error("bit rate above limit");

  property p_default_rate;
    @(posedge clk) disable iff (!rstn)
    ce && sel == `MSAP_SEL_9600 |=> rate == `MSAP_BPS_9600;
  endproperty
  a_default_rate: assert property (p_default_rate)
    else $error("default select not 9600");

  property p_tick_gap;
    @(posedge clk) disable iff (!rstn)
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("bit ticks too close");

endmodule

// File: msap_master_model.sv
`timescale 1ns/1ps
`include "msap_map.svh"

module msap_master_model
  import msap_pkg::*;
(
  // clock
  input wire logic clk,
  // request side
  output logic req_valid,
  output msap_req_t req,
  // reply side
  input wire logic rsp_valid,
  input wire msap_rsp_t rsp
);
  initial begin
    req_valid = 1'h0;
    req = '0;
  end

  // ------------------------------------------------------------
  // one request, held until the taking edge
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] slave, input logic [7:0] func,
      input logic [15:0] addr, input logic [15:0] data,
      output logic got, output msap_rsp_t r);
    @(posedge clk);
    req_valid <= 1'h1;
    req <= '{slave, func, addr, data};
    @(posedge clk);
    req_valid <= 1'h0;
    // released fields show a changed pattern
    req <= ~req;
    #1;
    got = rsp_valid;
    r = rsp;
  endtask
endmodule

// File: test_modbus_slave_address_programming.sv
`timescale 1ns/1ps
`include "msap_map.svh"

module test_modbus_slave_address_programming
  import msap_pkg::*;
;
  localparam int unsigned HZ = 768000;
  logic clk, rstn, ce, req_valid, rsp_valid, armed, bit_tick;
  msap_req_t req;
  msap_rsp_t rsp;
  logic [15:0] node_addr, bit_rate;
  logic [2:0] baud_sel;
  msap_frame_t frame;
  int n_mismatch = 0;
  int checks = 0;
  logic [15:0] rates [8] = '{`MSAP_BPS_9600, `MSAP_BPS_19200,
    `MSAP_BPS_38400, `MSAP_BPS_4800, `MSAP_BPS_2400, `MSAP_BPS_1200,
    `MSAP_BPS_38400, `MSAP_BPS_38400};

  msap_addr_bank #(.CLK_HZ(HZ)) dut (.CLK(clk), .RSTN(rstn), .CE(ce),
    .REQ_VALID(req_valid), .REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp),
    .NODE_ADDR(node_addr), .ARMED(armed), .BAUD_SEL(baud_sel),
    .BIT_RATE(bit_rate), .BIT_TICK(bit_tick), .FRAME(frame));

  msap_master_model m (.clk(clk), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp));

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [49:0] got, input logic [49:0] exp,
      input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // ------------------------------------------------------------
  // bus transfers
  // ------------------------------------------------------------
  task automatic tx(input logic [7:0] s, input logic [7:0] f,
      input logic [15:0] a, input logic [15:0] d, input logic exc,
      input logic [15:0] e, input string msg);
    logic got;
    msap_rsp_t r;
    logic [15:0] rd;
    m.xfer(s, f, a, d, got, r);
    rd = exc ? {8'h00, r.data[7:0]} : r.data;
    chk_rsp({got, r.exc, r.slave, r.func, r.reg_addr, rd},
      {1'h1, exc, s, exc ? (f | `MSAP_EXC_FLAG) : f, a, e}, msg);
  endtask

  task automatic quiet(input logic [7:0] s, input string msg);
    logic got;
    msap_rsp_t r;
    m.xfer(s, `MSAP_FC_READ_HOLD, `MSAP_REG_NODE, 16'h0001, got, r);
    chk_val({15'h0000, got}, 16'h0000, msg);
  endtask

  task automatic unlock(input logic [7:0] s);
    tx(s, 8'h06, 16'h0004, 16'h55AA, 1'h0, 16'h55AA, "unlock");
  endtask

  task automatic set_node(input logic [7:0] s, input logic [15:0] v);
    unlock(s);
    tx(s, 8'h06, 16'h0005, v, 1'h0, v, "node write");
    chk_val(node_addr, v, "node stored");
  endtask

  task automatic tick_period(output int n);
    n = 0;
    for (int i = 0; i < 2000 && bit_tick !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      n++;
      if (bit_tick === 1'h1) begin
        return;
      end
    end
    n_mismatch++;
    $display("[FAIL] %0t bit tick timeout", $time);
    end_of_test();
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    rstn = 1'h0;
    ce = 1'h1;
    baud_sel = 3'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    #1;
    chk_val(node_addr, `MSAP_NODE_RST, "reset node");
    chk_val({15'h0000, armed}, 16'h0000, "reset armed");
    chk_val(bit_rate, `MSAP_BPS_9600, "reset rate");
    chk_val({9'h000, frame}, 16'h0041, "frame format");
    done("reset");
    tx(8'h02, 8'h03, 16'h0005, 16'h0001, 1'h0, 16'h0002, "read");
    quiet(8'h03, "other node");
    tx(8'h02, 8'h06, 16'h0005, 16'h0010, 1'h1, 16'h0003, "no key");
    tx(8'h02, 8'h06, 16'h0004, 16'h1234, 1'h1, 16'h0003, "bad key");
    chk_val({15'h0000, armed}, 16'h0000, "bad key armed");
    unlock(8'h02);
    chk_val({15'h0000, armed}, 16'h0001, "armed");
    tx(8'h02, 8'h03, 16'h0005, 16'h0001, 1'h0, 16'h0002, "between");
    tx(8'h02, 8'h06, 16'h0005, 16'h0010, 1'h1, 16'h0003, "disarm");
    unlock(8'h02);
    tx(8'h02, 8'h06, 16'h0005, 16'h00F8, 1'h1, 16'h0003, "over");
    unlock(8'h02);
    tx(8'h02, 8'h06, 16'h0005, 16'h0000, 1'h1, 16'h0003, "zero");
    chk_val(node_addr, 16'h0002, "node kept");
    done("protection");
    set_node(8'h02, `MSAP_NODE_MIN);
    set_node(8'h01, `MSAP_NODE_MAX);
    quiet(8'h02, "old node");
    set_node(8'hF7, 16'h0010);
    tx(8'h10, 8'h10, 16'h0005, 16'h0000, 1'h1, 16'h0001, "func");
    tx(8'h10, 8'h06, 16'h0007, 16'h0000, 1'h1, 16'h0002, "reg");
    tx(8'h10, 8'h03, 16'h0004, 16'h0001, 1'h1, 16'h0002, "wo");
    tx(8'h10, 8'h03, 16'h0005, 16'h0002, 1'h1, 16'h0003, "qty");
    quiet(8'h00, "broadcast");
    unlock(8'h10);
    tx(8'h10, 8'h06, 16'h0004, 16'h0000, 1'h1, 16'h0003, "rekey");
    chk_val({15'h0000, armed}, 16'h0000, "rekey armed");
    @(posedge clk);
    ce <= 1'h0;
    quiet(8'h10, "frozen");
    @(posedge clk);
    ce <= 1'h1;
    done("change");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      baud_sel <= 3'(i);
      repeat (3) @(posedge clk);
      #1;
      chk_val(bit_rate, rates[i], "rate");
      tick_period(n);
      tick_period(n);
      chk_val(16'(n), 16'(HZ / rates[i]), "tick period");
    end
    done("rates");
    end_of_test();
  end
endmodule
